// ### src/kmse_pkg.sv
// kmse_pkg: constants and carrier types of the keyboard matrix scan encoder
package kmse_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PHASE_PERIOD_NS = 6000;
  localparam int PHASE_PULSE_NS = 1500;
  localparam int STROBE_NS = 6000;
  localparam int SENSE_MIN_NS = 1500;
  localparam int REPEAT_PERIOD_US = 60000;
  localparam int PHASE_PERIOD_CYC = PHASE_PERIOD_NS * CLK_MHZ / 1000;
  localparam int PHASE_PULSE_CYC = (PHASE_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE2_START_CYC = PHASE_PERIOD_CYC / 2;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SENSE_MIN_CYC = (SENSE_MIN_NS * CLK_MHZ) / 1000;
  localparam int REPEAT_TICKS = REPEAT_PERIOD_US * 1000 / PHASE_PERIOD_NS;

  // ------------------------------------------------------------------
  // matrix layout
  // ------------------------------------------------------------------
  localparam logic [3:0] FUNC_COL = 4'hf;
  localparam logic [3:0] SPECIAL_COL = 4'he;
  localparam int FN_SHIFT = 0;
  localparam int FN_LOCK = 1;
  localparam int FN_UPPER = 2;
  localparam int FN_CTRL = 3;
  localparam int FN_REPEAT = 4;
  localparam int FN_LOCAL = 5;
  localparam int FN_RESET = 6;
  localparam int FN_BREAK = 7;
  localparam int FN_COUNT = 8;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [11:0] KEY_DATA_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] CONTROL_OFS = 12'h008;
  localparam int KD_READY_BIT = 8;
  localparam int ST_THRESH_BIT = 3;
  localparam int ST_FN_LSB = 4;
  localparam int ST_REPEAT_BIT = 12;
  localparam int ST_STROBE_BIT = 13;
  localparam int CTL_SCAN_EN_BIT = 0;
  localparam int CTL_REPEAT_EN_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h3;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    KMSE_IDLE = 3'h0,
    KMSE_PENDING = 3'h1,
    KMSE_CONFIRM = 3'h3,
    KMSE_LOAD = 3'h2,
    KMSE_HELD = 3'h6
  } kmse_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } kmse_apb_req_t;

endpackage : kmse_pkg

// ### src/kmse_code_rom.sv
// kmse_code_rom: encoding table giving the upper nibble of a key code
`timescale 1ns/1ps
module kmse_code_rom (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [6:0] addr,
  output logic [3:0] data_ff
);
  import kmse_pkg::*;

  logic [3:0] nxt_data;

  // ------------------------------------------------------------------
  // table: addr = {shift, upper, ctrl, column}
  // ------------------------------------------------------------------
  always_comb begin
    nxt_data = 4'h0;
    if (addr[3:0] == SPECIAL_COL) begin
      nxt_data = 4'h8;
    end else if (addr[3:0] == FUNC_COL) begin
      nxt_data = 4'h0;
    end else if (addr[3] == 1'b0) begin
      if (addr[4]) begin
        nxt_data = addr[0] ? 4'h1 : 4'h0;
      end else if (addr[6] || addr[5]) begin
        nxt_data = addr[0] ? 4'h5 : 4'h4;
      end else begin
        nxt_data = addr[0] ? 4'h7 : 4'h6;
      end
    end else if (addr[3:2] == 2'h2) begin
      nxt_data = addr[6] ? 4'h2 : 4'h3;
    end else begin
      nxt_data = 4'h2;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ff <= 4'h0;
    end else begin
      data_ff <= nxt_data;
    end
  end

endmodule : kmse_code_rom

// ### src/kmse_strobe_gen.sv
// kmse_strobe_gen: one fixed-width ready pulse per trigger
`timescale 1ns/1ps
module kmse_strobe_gen (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic trigger,
  output logic strobe_ff
);
  import kmse_pkg::*;

  localparam logic [9:0] WIDTH = 10'(STROBE_CYC);

  logic [9:0] cnt_ff;

  // ------------------------------------------------------------------
  // pulse timer, a new trigger restarts the pulse
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 10'h000;
      strobe_ff <= 1'b0;
    end else if (trigger) begin
      cnt_ff <= WIDTH - 10'h001;
      strobe_ff <= 1'b1;
    end else if (cnt_ff != 10'h000) begin
      cnt_ff <= cnt_ff - 10'h001;
    end else begin
      strobe_ff <= 1'b0;
    end
  end

endmodule : kmse_strobe_gen

// ### src/kmse_scan_encoder.sv
// kmse_scan_encoder: key matrix scanner, sequence detector and code latch
//
// Contract
// - matrix is sixteen columns by sixteen rows
// - at most one column driven at a time
// - pressed key at selected address gives detection
// - reject spurious hits, service closures in order
// - no closure: threshold control selects high threshold
// - valid closure: threshold control selects low threshold
// - each valid closure loads the output latch
// - low code nibble is the row count
// - high nibble from table by column and modifiers
// - latch load fires a 6 us ready strobe
// - latch holds eight code bits, ascii below
// - top code bit marks special control characters
// - repeat counts only with repeat and held key
// - repeat pulse restrobes and inhibits sequence detector
// - repeat operation blocks further latch loads
// - function column decodes flags and connector outputs
// - shift, upper case, control address the table
// - two non-overlapping phases, 6 us, 1.5 us low
// - all rows scanned before column advances
// - key needs detection on two consecutive scans
// - detection must last over 1.5 us
`timescale 1ns/1ps
module kmse_scan_encoder #(
  parameter int REPEAT_TICKS_P = kmse_pkg::REPEAT_TICKS
) (
  input wire logic clk,
  input wire logic reset_n,
  input kmse_pkg::kmse_apb_req_t apb_req,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic key_sense_n,
  output logic [15:0] col_drive_n_ff,
  output logic [3:0] row_sel_ff,
  output logic kbd_phase1_n_ff,
  output logic kbd_phase2_n_ff,
  output logic sense_threshold_ctl_ff,
  output logic [7:0] key_code_bits_ff,
  output logic kbd_strobe_ff,
  output logic local_mode_ff,
  output logic reset_req_ff,
  output logic break_request_out_ff
);
  import kmse_pkg::*;

  localparam logic [9:0] PH_LAST = 10'(PHASE_PERIOD_CYC - 1);
  localparam logic [9:0] PH_PULSE = 10'(PHASE_PULSE_CYC);
  localparam logic [9:0] PH2_START = 10'(PHASE2_START_CYC);
  localparam logic [9:0] PH2_END = 10'(PHASE2_START_CYC + PHASE_PULSE_CYC);
  localparam logic [7:0] SENSE_MIN = 8'(SENSE_MIN_CYC);
  localparam logic [15:0] REP_LAST = 16'(REPEAT_TICKS_P - 1);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [9:0] ph_ff;
  logic [7:0] scan_ff, low_cnt_ff, addr_ff;
  logic [3:0] col, row, rom_data;
  logic sense_s1_ff, sense_s2_ff, hit_ff, data_ready_ff;
  kmse_state_t state_ff, nxt_state;
  logic [FN_COUNT-1:0] fn_acc_ff, fn_ff;
  logic step, at_addr, fn_commit, load;
  logic repeat_active, repeat_pulse;
  logic [15:0] rep_cnt_ff;
  logic [6:0] rom_addr;
  logic [1:0] control_ff;
  logic scan_en, repeat_en;
  logic apb_setup, apb_access, apb_write, apb_read_key;
  logic [31:0] nxt_rdata;
  logic nxt_slverr;

  assign col = scan_ff[7:4];
  assign row = scan_ff[3:0];
  assign scan_en = control_ff[CTL_SCAN_EN_BIT];
  assign repeat_en = control_ff[CTL_REPEAT_EN_BIT];

  // ------------------------------------------------------------------
  // two-phase keyboard timing
  // ------------------------------------------------------------------
  assign step = (ph_ff == PH_LAST);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_ff <= PH_LAST;
    end else if (step) begin
      ph_ff <= 10'h000;
    end else begin
      ph_ff <= ph_ff + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kbd_phase1_n_ff <= 1'b1;
      kbd_phase2_n_ff <= 1'b1;
    end else begin
      kbd_phase1_n_ff <= !(step || ph_ff < PH_PULSE - 10'h001);
      kbd_phase2_n_ff <= !(ph_ff >= PH2_START - 10'h001 &&
                           ph_ff < PH2_END - 10'h001);
    end
  end

  // ------------------------------------------------------------------
  // column and row scanner
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_ff <= 8'h00;
      row_sel_ff <= 4'h0;
    end else if (step && scan_en) begin
      scan_ff <= scan_ff + 8'h01;
      row_sel_ff <= row + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      col_drive_n_ff <= 16'hffff;
    end else if (scan_en && !step && ph_ff >= PH_PULSE - 10'h001) begin
      col_drive_n_ff <= ~(16'h0001 << col);
    end else begin
      col_drive_n_ff <= 16'hffff;
    end
  end

  // ------------------------------------------------------------------
  // sense input: synchroniser and width filter
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_s1_ff <= 1'b1;
      sense_s2_ff <= 1'b1;
    end else begin
      sense_s1_ff <= key_sense_n;
      sense_s2_ff <= sense_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_ff <= 8'h00;
    end else if (step || sense_s2_ff) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hff) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_ff <= 1'b0;
    end else if (step) begin
      hit_ff <= 1'b0;
    end else if (!sense_s2_ff && low_cnt_ff == SENSE_MIN) begin
      hit_ff <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // function column latch and decoder
  // ------------------------------------------------------------------
  assign fn_commit = step && scan_en && col == FUNC_COL && row == 4'hf;

  generate
    for (genvar i = 0; i < FN_COUNT; i++) begin : g_fn
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          fn_acc_ff[i] <= 1'b0;
          fn_ff[i] <= 1'b0;
        end else if (fn_commit) begin
          fn_acc_ff[i] <= 1'b0;
          fn_ff[i] <= fn_acc_ff[i];
        end else if (step && scan_en && col == FUNC_COL &&
                     row == 4'(i) && hit_ff) begin
          fn_acc_ff[i] <= 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      local_mode_ff <= 1'b0;
      reset_req_ff <= 1'b0;
      break_request_out_ff <= 1'b0;
    end else begin
      local_mode_ff <= fn_ff[FN_LOCAL];
      reset_req_ff <= fn_ff[FN_RESET];
      break_request_out_ff <= fn_ff[FN_BREAK];
    end
  end

  // ------------------------------------------------------------------
  // sequence detector
  // ------------------------------------------------------------------
  assign at_addr = step && (scan_ff == addr_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      KMSE_IDLE: begin
        if (step && scan_en && hit_ff && col != FUNC_COL &&
            !repeat_active) begin
          nxt_state = KMSE_PENDING;
        end
      end
      KMSE_PENDING: begin
        if (at_addr) begin
          nxt_state = hit_ff ? KMSE_CONFIRM : KMSE_IDLE;
        end
      end
      KMSE_CONFIRM: begin
        nxt_state = KMSE_LOAD;
      end
      KMSE_LOAD: begin
        nxt_state = KMSE_HELD;
      end
      KMSE_HELD: begin
        if (at_addr && !hit_ff) begin
          nxt_state = KMSE_IDLE;
        end
      end
      default: begin
        nxt_state = KMSE_IDLE;
      end
    endcase
    if (!scan_en) begin
      nxt_state = KMSE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= KMSE_IDLE;
      addr_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == KMSE_IDLE && nxt_state == KMSE_PENDING) begin
        addr_ff <= scan_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense_threshold_ctl_ff <= 1'b1;
    end else begin
      sense_threshold_ctl_ff <= (nxt_state == KMSE_IDLE ||
                                 nxt_state == KMSE_PENDING);
    end
  end

  // ------------------------------------------------------------------
  // repeat counter
  // ------------------------------------------------------------------
  assign repeat_active = repeat_en && fn_ff[FN_REPEAT] &&
                         state_ff == KMSE_HELD;
  assign repeat_pulse = repeat_active && step && rep_cnt_ff == REP_LAST &&
                        nxt_state == KMSE_HELD;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rep_cnt_ff <= 16'h0000;
    end else if (!repeat_active || repeat_pulse) begin
      rep_cnt_ff <= 16'h0000;
    end else if (step) begin
      rep_cnt_ff <= rep_cnt_ff + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // encoding table, output latch and strobe
  // ------------------------------------------------------------------
  assign rom_addr = {fn_ff[FN_SHIFT] | fn_ff[FN_LOCK], fn_ff[FN_UPPER],
                     fn_ff[FN_CTRL], addr_ff[7:4]};
  assign load = (state_ff == KMSE_LOAD) && !repeat_active;

  kmse_code_rom u_rom (
    .clk(clk),
    .reset_n(reset_n),
    .addr(rom_addr),
    .data_ff(rom_data)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_code_bits_ff <= 8'h00;
    end else if (load) begin
      key_code_bits_ff <= {rom_data, addr_ff[3:0]};
    end
  end

  kmse_strobe_gen u_strobe (
    .clk(clk),
    .reset_n(reset_n),
    .trigger(load || repeat_pulse),
    .strobe_ff(kbd_strobe_ff)
  );

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------
  assign apb_setup = apb_req.psel && !apb_req.penable;
  assign apb_access = apb_req.psel && apb_req.penable && pready_ff;
  assign apb_write = apb_access && apb_req.pwrite;
  assign apb_read_key = apb_access && !apb_req.pwrite &&
                        apb_req.paddr == KEY_DATA_OFS;

  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_slverr = 1'b0;
    case (apb_req.paddr)
      KEY_DATA_OFS: begin
        nxt_rdata[7:0] = key_code_bits_ff;
        nxt_rdata[KD_READY_BIT] = data_ready_ff;
      end
      STATUS_OFS: begin
        nxt_rdata[2:0] = state_ff;
        nxt_rdata[ST_THRESH_BIT] = sense_threshold_ctl_ff;
        nxt_rdata[ST_FN_LSB +: FN_COUNT] = fn_ff;
        nxt_rdata[ST_REPEAT_BIT] = repeat_active;
        nxt_rdata[ST_STROBE_BIT] = kbd_strobe_ff;
      end
      CONTROL_OFS: begin
        nxt_rdata[1:0] = control_ff;
      end
      default: begin
        nxt_slverr = 1'b1;
      end
    endcase
    if (apb_req.pwrite) begin
      nxt_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && nxt_slverr;
      prdata_ff <= apb_setup ? nxt_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_ff <= CONTROL_RESET;
    end else if (apb_write && apb_req.paddr == CONTROL_OFS) begin
      control_ff <= apb_req.pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ready_ff <= 1'b0;
    end else if (load || repeat_pulse) begin
      data_ready_ff <= 1'b1;
    end else if (apb_read_key) begin
      data_ready_ff <= 1'b0;
    end
  end

endmodule : kmse_scan_encoder

// ### testbench/kmse_scan_encoder_checker.sv
// kmse_scan_encoder_checker: port assertions of the scan encoder
`timescale 1ns/1ps
module kmse_scan_encoder_checker #(
  parameter int REPEAT_TICKS_P = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input kmse_pkg::kmse_apb_req_t apb_req,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic [15:0] col_drive_n_ff,
  input wire logic [3:0] row_sel_ff,
  input wire logic kbd_phase1_n_ff,
  input wire logic kbd_phase2_n_ff,
  input wire logic sense_threshold_ctl_ff,
  input wire logic [7:0] key_code_bits_ff,
  input wire logic kbd_strobe_ff
);
  import kmse_pkg::*;
  // ------
  // pulse length counters
  // ------
  logic [9:0] stb_len_ff;
  logic [7:0] ph1_len_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stb_len_ff <= 10'h000;
    end else begin
      stb_len_ff <= kbd_strobe_ff ? stb_len_ff + 10'h001 : 10'h000;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph1_len_ff <= 8'h00;
    end else begin
      ph1_len_ff <= !kbd_phase1_n_ff ? ph1_len_ff + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ------
  // assertions
  // ------
  a_one_column: assert property ($onehot0(~col_drive_n_ff))
    else $error("more than one column driven");
  a_rows_settled: assert property ($changed(row_sel_ff) |->
    (col_drive_n_ff == 16'hffff || $past(col_drive_n_ff) == 16'hffff))
    else $error("row changed while a column was driven");
  a_ready_setup: assert property (apb_req.psel && !apb_req.penable
    |=> pready_ff) else $error("no ready after setup");
  a_ready_single: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside access");
  a_phase_apart: assert property (kbd_phase1_n_ff || kbd_phase2_n_ff)
    else $error("phases overlap");
  a_phase_width: assert property ($rose(kbd_phase1_n_ff) |->
    ph1_len_ff == PHASE_PULSE_CYC) else $error("phase pulse width");
  a_strobe_width: assert property ($fell(kbd_strobe_ff) |->
    stb_len_ff == STROBE_CYC) else $error("strobe width");
  a_strobe_thresh: assert property ($rose(kbd_strobe_ff) |->
    !sense_threshold_ctl_ff) else $error("threshold high at strobe");
  a_load_strobe: assert property ($changed(key_code_bits_ff) |->
    $rose(kbd_strobe_ff)) else $error("load without strobe");
endmodule : kmse_scan_encoder_checker

bind kmse_scan_encoder kmse_scan_encoder_checker #(
  .REPEAT_TICKS_P(REPEAT_TICKS_P)
) u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .apb_req(apb_req),
  .prdata_ff(prdata_ff),
  .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff),
  .col_drive_n_ff(col_drive_n_ff),
  .row_sel_ff(row_sel_ff),
  .kbd_phase1_n_ff(kbd_phase1_n_ff),
  .kbd_phase2_n_ff(kbd_phase2_n_ff),
  .sense_threshold_ctl_ff(sense_threshold_ctl_ff),
  .key_code_bits_ff(key_code_bits_ff),
  .kbd_strobe_ff(kbd_strobe_ff)
);

// ### testbench/kmse_key_matrix.sv
// kmse_key_matrix: capacitive key matrix seen from the scan pins
`timescale 1ns/1ps
module kmse_key_matrix (
  input wire logic [15:0] col_drive_n,
  input wire logic [3:0] row_sel,
  input wire logic [255:0] pressed,
  output logic key_sense_n
);
  // ------
  // sense line, pulled high unless a pressed key couples
  // ------
  always_comb begin
    key_sense_n = 1'b1;
    for (int c = 0; c < 16; c++) begin
      if (!col_drive_n[c] && pressed[{c[3:0], row_sel}]) begin
        key_sense_n = 1'b0;
      end
    end
  end
endmodule : kmse_key_matrix

// ### testbench/kmse_scan_encoder_test.sv
// kmse_scan_encoder_test: self-checking bench of the scan encoder
`timescale 1ns/1ps
module kmse_scan_encoder_test;
  import kmse_pkg::*;
  localparam int RPT = 4;
  logic clk, reset_n, key_sense_n, pready, pslverr, ph1_n, ph2_n;
  logic thr, stb, local_mode, rst_req, break_request_out, err, seen;
  kmse_apb_req_t req;
  logic [31:0] prdata, rd;
  logic [15:0] cols_n;
  logic [3:0] row_sel, row;
  logic [7:0] code;
  logic [11:0] a;
  logic [255:0] pressed;
  int n_errors, cmp_count, i;

  kmse_scan_encoder #(.REPEAT_TICKS_P(RPT)) dut (
    .clk(clk), .reset_n(reset_n), .apb_req(req), .prdata_ff(prdata),
    .pready_ff(pready), .pslverr_ff(pslverr), .key_sense_n(key_sense_n),
    .col_drive_n_ff(cols_n), .row_sel_ff(row_sel),
    .kbd_phase1_n_ff(ph1_n), .kbd_phase2_n_ff(ph2_n),
    .sense_threshold_ctl_ff(thr), .key_code_bits_ff(code),
    .kbd_strobe_ff(stb), .local_mode_ff(local_mode),
    .reset_req_ff(rst_req), .break_request_out_ff(break_request_out)
  );
  kmse_key_matrix u_keys (
    .col_drive_n(cols_n), .row_sel(row_sel), .pressed(pressed),
    .key_sense_n(key_sense_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ------
  // shared tasks
  // ------
  task finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k == 16) begin
      chk("apb_ready", 32'h1, 32'h0);
      finish_test();
    end
  endtask : apb

  task wait_lvl(input int sel, input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clk);
      if ((sel == 0 ? stb : thr) === lvl) break;
    end
    if (k == lim) begin
      chk("wait_level", {31'h0, lvl}, {31'h0, ~lvl});
      finish_test();
    end
  endtask : wait_lvl

  function automatic logic [31:0] exp_kd(input logic rdy, input logic [3:0] r);
    return {23'h0, rdy, 4'h8, r};
  endfunction : exp_kd
  // ------
  // main sequence
  // ------
  initial begin
    void'($urandom(58913));
    reset_n = 1'b0;
    req = '0;
    pressed = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    chk("cols_rst", 32'hffff, {16'h0, cols_n});
    chk("thr_rst", 32'h1, {31'h0, thr});
    chk("stb_rst", 32'h0, {31'h0, stb});
    reset_n <= 1'b1;
    apb(1'b0, CONTROL_OFS, 32'h0);
    chk("control", 32'h3, rd);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_idle", 32'h8, rd);
    apb(1'b1, CONTROL_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk("cols_off", 32'hffff, {16'h0, cols_n});
    apb(1'b1, CONTROL_OFS, 32'h3);
    apb(1'b0, CONTROL_OFS, 32'h0);
    chk("control_on", 32'h3, rd);
    for (i = 0; i < 6; i++) begin
      a = 12'h00c + 12'(4 * $urandom_range(1020, 0));
      apb(i[0], a, $urandom());
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_rd", 32'h0, rd);
    end
    apb(1'b1, KEY_DATA_OFS, $urandom());
    apb(1'b1, STATUS_OFS, $urandom());
    apb(1'b0, KEY_DATA_OFS, 32'h0);
    chk("kd_readonly", 32'h0, rd);
    row = 4'($urandom_range(15, 0));
    pressed[{SPECIAL_COL, row}] <= 1'b1;
    pressed[{FUNC_COL, 4'(FN_REPEAT)}] <= 1'b1;
    pressed[{FUNC_COL, 4'(FN_LOCAL)}] <= 1'b1;
    wait_lvl(0, 1'b1, 400000);
    chk("code", exp_kd(1'b0, row), {24'h0, code});
    chk("thr_low", 32'h0, {31'h0, thr});
    chk("fn_outs", 32'h4, {29'h0, local_mode, rst_req, break_request_out});
    pressed[{FUNC_COL, 4'(FN_REPEAT)}] <= 1'b0;
    pressed[{FUNC_COL, 4'(FN_LOCAL)}] <= 1'b0;
    apb(1'b0, KEY_DATA_OFS, 32'h0);
    chk("kd_ready", exp_kd(1'b1, row), rd);
    apb(1'b0, KEY_DATA_OFS, 32'h0);
    chk("kd_cleared", exp_kd(1'b0, row), rd);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_held", 32'h3306, rd);
    for (i = 0; i < 3; i++) begin
      wait_lvl(0, 1'b0, 700);
      wait_lvl(0, 1'b1, RPT * 600 + 700);
      chk("repeat_code", exp_kd(1'b0, row), {24'h0, code});
    end
    apb(1'b0, KEY_DATA_OFS, 32'h0);
    chk("kd_repeat", exp_kd(1'b1, row), rd);
    pressed <= '0;
    wait_lvl(1, 1'b1, 200000);
    chk("thr_idle", 32'h1, {31'h0, thr});
    chk("fn_clear", 32'h0, {29'h0, local_mode, rst_req, break_request_out});
    seen = 1'b0;
    repeat (3000) begin
      @(posedge clk);
      if (stb !== 1'b0) seen = 1'b1;
    end
    chk("no_repeat", 32'h0, {31'h0, seen});
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_end", 32'h8, rd);
    finish_test();
  end
endmodule : kmse_scan_encoder_test
